// ==== hdl/tmrc_addr_cmp.sv ====
// Counts the low-order address bytes that must be sent.
// Assumes a valid reference flag that clears after every reset.
module tmrc_addr_cmp (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] ref_addr,
  input  wire logic        ref_valid,
  output logic      [2:0]  nbytes
);

  // Highest changed byte sets the count; invalid reference sends all
  always_comb begin
    nbytes = 3'h1;
    if (!ref_valid) begin
      nbytes = 3'h4;
    end else if (addr[31:24] != ref_addr[31:24]) begin
      nbytes = 3'h4;
    end else if (addr[23:16] != ref_addr[23:16]) begin
      nbytes = 3'h3;
    end else if (addr[15:8] != ref_addr[15:8]) begin
      nbytes = 3'h2;
    end
  end

endmodule

// ==== hdl/tmrc_core.sv ====
// Trace macrocell reset handling and output compression.
// Assumes the processor interface, programming strobes and trace sink
// all run on ref_clk; core_reset comes from another domain.
//
// Operation
// R1: Processor reset leaves macrocell registers untouched
// R2: Processor reset inserts exception packet, cause reset
// R3: Macrocell reset restores all resettable registers
// R4: Power-on reset performs full macrocell reset
// R5: Programming bit writes reset state groups
// R6: Reset sets power-down and programming bits
// R7: Undefined-reset bits are never relied upon
// R8: Addresses only for non-inferable branch destinations
// R9: Unchanged high address bytes are omitted
// R10: Output only at full interface width
// R11: Trace isa/security changes, skip bytecodes
// R12: Debug port, coprocessor or bus write registers
// R13: Direct branch gives executed or not-executed atom
// R14: Reset invalidates address reference, next full
`include "tmrc_defs.svh"

module tmrc_core (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              por_n,
  input  wire logic              core_reset,
  input  wire tmrc_pkg::tmrc_wp_t wp,
  output logic                   wp_ready,
  input  wire logic              cfg_we,
  input  wire tmrc_pkg::tmrc_ctrl_t cfg_wdata,
  output tmrc_pkg::tmrc_ctrl_t   cfg_rdata,
  output logic                   trace_valid,
  output logic      [31:0]       trace_data,
  input  wire logic              trace_ready
);

  // ****************************************************************
  // Reset combination
  // ****************************************************************
  // Either reset performs the whole macrocell reset
  logic rst_n;
  assign rst_n = resetn && por_n; // R4

  // ****************************************************************
  // Processor reset synchroniser and edge
  // ****************************************************************
  logic crst_s1_q;
  logic crst_s2_q;
  logic crst_d_q;
  logic crst_pend_q;
  logic crst_rise;

  // Two stages before any logic looks at the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crst_s1_q <= 1'h0;
      crst_s2_q <= 1'h0;
      crst_d_q  <= 1'h0;
    end else begin
      crst_s1_q <= core_reset;
      crst_s2_q <= crst_s1_q;
      crst_d_q  <= crst_s2_q;
    end
  end

  // Rising edge only: a processor reset held for many cycles still
  // yields one exception packet, not one per cycle
  assign crst_rise = crst_s2_q && !crst_d_q;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Only the macrocell reset touches it; processor reset does not
  tmrc_pkg::tmrc_ctrl_t ctrl_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q.pwrdn <= `TMRC_PWRDN_RST; // R6
      ctrl_q.prog  <= `TMRC_PROG_RST; // R6
      ctrl_q.bcast <= `TMRC_BCAST_RST; // R3
      ctrl_q.tren  <= `TMRC_TREN_RST; // R3
    end else if (cfg_we) begin
      ctrl_q <= cfg_wdata; // R12
    end
  end
  // Read-back comes straight from the register
  assign cfg_rdata = ctrl_q; // R1

  // Writes of the programming bit are partial resets
  logic prog_wr1;
  logic prog_wr0;
  assign prog_wr1 = cfg_we && cfg_wdata.prog;
  assign prog_wr0 = cfg_we && !cfg_wdata.prog;

  // Trace only while enabled, out of programming and powered up;
  // waypoints arriving otherwise are dropped, not queued
  logic tracing;
  assign tracing = ctrl_q.tren && !ctrl_q.prog && !ctrl_q.pwrdn;

  // ****************************************************************
  // Pending processor-reset exception
  // ****************************************************************
  // Writing 1 to the programming bit drops a queued exception;
  // a new edge in the same cycle still wins
  logic exc_taken;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crst_pend_q <= 1'h0;
    end else if (crst_rise && tracing) begin
      crst_pend_q <= 1'h1; // R2
    end else if (exc_taken || prog_wr1) begin
      crst_pend_q <= 1'h0; // R5
    end
  end

  // ****************************************************************
  // Address reference and instruction-set tracking
  // ****************************************************************
  logic [31:0] ref_addr_q;
  logic        ref_vld_q;
  logic [1:0]  isa_q;
  logic        sec_q;
  logic        wp_take;
  logic        need_addr;
  logic [2:0]  nbytes;

  // Writing 0 restarts the stream, so the reference is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_addr_q <= 32'h0;
      ref_vld_q  <= 1'h0; // R14
    end else if (prog_wr0 || exc_taken) begin
      ref_vld_q  <= 1'h0; // R5
    end else if (wp_take && need_addr) begin
      ref_addr_q <= wp.target;
      ref_vld_q  <= 1'h1;
    end
  end

  // Isa state only meaningful after a change packet; reset value kept
  // defined so no logic reads an unknown
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      isa_q <= 2'h0; // R7
      sec_q <= 1'h0; // R7
    end else if (wp_take && wp.isa_chg) begin
      isa_q <= wp.isa;
      sec_q <= wp.sec;
    end
  end

  // The count is formed before this waypoint updates the reference,
  // so the comparison always sees the previously traced address
  tmrc_addr_cmp u_cmp (
    .addr      (wp.target),
    .ref_addr  (ref_addr_q),
    .ref_valid (ref_vld_q),
    .nbytes    (nbytes)
  );

  // Indirect taken branch, or broadcast of direct taken branch
  assign need_addr = wp.passed && (!wp.direct || ctrl_q.bcast); // R8

  // ****************************************************************
  // Packet sequencer
  // ****************************************************************
  tmrc_pkg::tmrc_state_t st_q;
  logic [31:0] addr_q;
  logic [2:0]  left_q;
  logic [1:0]  idx_q;
  logic        isa_pend_q;
  logic [7:0]  byte_out;
  logic        byte_vld;
  logic        pk_ready;

  assign wp_ready  = (st_q == tmrc_pkg::TMRC_IDLE) && !crst_pend_q;
  assign wp_take   = wp.valid && wp_ready && tracing && !wp.bytecode; // R11
  assign exc_taken = (st_q == tmrc_pkg::TMRC_EXC) && pk_ready && idx_q[0];

  // Sequencer state and payload registers
  // One waypoint is handled at a time; wp_ready stays low meanwhile
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= tmrc_pkg::TMRC_IDLE;
      addr_q     <= 32'h0;
      left_q     <= 3'h0;
      idx_q      <= 2'h0;
      isa_pend_q <= 1'h0;
    end else if (prog_wr1) begin
      // Abort: the packer is cleared in the same cycle
      st_q       <= tmrc_pkg::TMRC_IDLE; // R5
      isa_pend_q <= 1'h0;
    end else begin
      case (st_q)
        tmrc_pkg::TMRC_IDLE: begin
          idx_q <= 2'h0;
          if (crst_pend_q) begin
            st_q <= tmrc_pkg::TMRC_EXC; // R2
          end else if (wp_take) begin
            addr_q     <= wp.target;
            // Atom-only waypoints owe no address bytes
            left_q     <= need_addr ? nbytes : 3'h0; // R9
            isa_pend_q <= wp.isa_chg; // R11
            st_q       <= need_addr ? tmrc_pkg::TMRC_HDR
                                    : tmrc_pkg::TMRC_BODY;
          end
        end
        tmrc_pkg::TMRC_HDR: begin
          if (pk_ready) begin
            st_q <= tmrc_pkg::TMRC_BODY;
          end
        end
        tmrc_pkg::TMRC_BODY: begin
          if (pk_ready) begin
            if (left_q > 3'h1) begin
              left_q <= left_q - 3'h1;
              addr_q <= {8'h0, addr_q[31:8]};
            end else begin
              left_q <= 3'h0;
              st_q   <= isa_pend_q ? tmrc_pkg::TMRC_ISA
                                   : tmrc_pkg::TMRC_IDLE;
            end
          end
        end
        tmrc_pkg::TMRC_ISA: begin
          if (pk_ready) begin
            isa_pend_q <= 1'h0;
            st_q       <= tmrc_pkg::TMRC_IDLE;
          end
        end
        tmrc_pkg::TMRC_EXC: begin
          if (pk_ready) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q[0]) begin
              st_q <= tmrc_pkg::TMRC_IDLE;
            end
          end
        end
        default: begin
          st_q <= tmrc_pkg::TMRC_IDLE;
        end
      endcase
    end
  end

  // Byte chosen by state; atom when no address is owed
  logic body_addr;
  logic atom_e;
  assign body_addr = (left_q != 3'h0);
  assign atom_e    = wp.passed;

  // Latched atom outcome for the body byte of an atom-only waypoint
  logic atom_e_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      atom_e_q <= 1'h0;
    end else if (wp_take) begin
      atom_e_q <= atom_e;
    end
  end

  // Byte offered to the packer in each state; idle offers none,
  // so the packer never fills a lane with filler
  always_comb begin
    byte_vld = 1'h1;
    byte_out = 8'h0;
    case (st_q)
      tmrc_pkg::TMRC_HDR: byte_out = `TMRC_HDR_ADDR; // R8
      tmrc_pkg::TMRC_BODY: begin
        if (body_addr && left_q > 3'h1) begin
          byte_out = addr_q[7:0] | `TMRC_CONT_BIT; // R9
        end else if (body_addr) begin
          // Last address byte: bit 7 clear, even when the byte is zero
          byte_out = addr_q[7:0] & 8'h7f; // R9
        end else begin
          byte_out = atom_e_q ? `TMRC_HDR_ATOM_E
                              : `TMRC_HDR_ATOM_N; // R13
        end
      end
      // Header code keeps its top five bits; state fills the low three
      tmrc_pkg::TMRC_ISA: byte_out = (`TMRC_HDR_ISTATE & 8'hf8)
                                     | {5'h0, sec_q, isa_q}; // R11
      // Exception header first, then the processor-reset cause
      tmrc_pkg::TMRC_EXC: byte_out = idx_q[0] ? `TMRC_EXC_PRST
                                              : `TMRC_HDR_EXC; // R2
      default: byte_vld = 1'h0;
    endcase
  end

  // ****************************************************************
  // Full-width output packing
  // ****************************************************************
  // A programming abort clears the packer so a restarted stream
  // never shares a word with bytes of the aborted one
  tmrc_packer u_pack (
    .ref_clk   (ref_clk),
    .resetn    (rst_n),
    .clr       (prog_wr1),
    .in_valid  (byte_vld),
    .in_byte   (byte_out),
    .in_ready  (pk_ready),
    .out_valid (trace_valid),
    .out_data  (trace_data),
    .out_ready (trace_ready)
  );

endmodule

// ==== hdl/tmrc_packer.sv ====
// Packs trace bytes into full-width words for the trace output.
// Assumes the sink may stall with ready low.
`include "tmrc_defs.svh"

module tmrc_packer (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clr,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_byte,
  output logic             in_ready,
  output logic             out_valid,
  output logic      [31:0] out_data,
  input  wire logic        out_ready
);

  logic [2:0]  cnt_q;
  logic [31:0] acc_q;
  logic        full;
  logic        take;

  // A word goes out only when every lane holds data
  assign full      = (cnt_q == 3'(`TMRC_OUT_BYTES));
  assign out_valid = full; // R10
  assign in_ready  = !full;
  assign take      = in_valid && in_ready;
  assign out_data  = acc_q;

  // Fill lanes from the bottom; first byte in is the low lane
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
      acc_q <= 32'h0;
    end else if (clr) begin
      cnt_q <= 3'h0;
    end else if (full && out_ready) begin
      cnt_q <= 3'h0;
    end else if (take) begin
      acc_q[cnt_q[1:0]*8 +: 8] <= in_byte;
      cnt_q                    <= cnt_q + 3'h1;
    end
  end

endmodule

// ==== include/tmrc_defs.svh ====
// Constants for the trace macrocell reset and compression block.
// Assumes inclusion by bare name from package and design files.
`ifndef TMRC_DEFS_SVH
`define TMRC_DEFS_SVH

// ****************************************************************
// Control bit reset values
// ****************************************************************
`define TMRC_PWRDN_RST     1'h1
`define TMRC_PROG_RST      1'h1
`define TMRC_BCAST_RST     1'h0
`define TMRC_TREN_RST      1'h0

// ****************************************************************
// Packet headers and causes
// ****************************************************************
`define TMRC_HDR_ATOM_E    8'h84
`define TMRC_HDR_ATOM_N    8'h80
`define TMRC_HDR_ADDR      8'h01
`define TMRC_HDR_EXC       8'h0e
`define TMRC_HDR_ISTATE    8'h0c
`define TMRC_EXC_PRST      8'h01
`define TMRC_CONT_BIT      8'h80

// ****************************************************************
// Output interface geometry
// ****************************************************************
`define TMRC_OUT_BYTES     4
`define TMRC_CNT_W         3

`endif

// ==== include/tmrc_pkg.sv ====
// Types for the trace macrocell reset and compression block.
// Assumes the defines header sits in the include path.
`include "tmrc_defs.svh"

package tmrc_pkg;

  // ****************************************************************
  // Waypoint event from the processor interface
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic        direct;
    logic        passed;
    logic        isa_chg;
    logic [1:0]  isa;
    logic        sec;
    logic        bytecode;
    logic [31:0] target;
  } tmrc_wp_t;

  // Control fields written over the programming interface
  typedef struct packed {
    logic pwrdn;
    logic prog;
    logic bcast;
    logic tren;
  } tmrc_ctrl_t;

  typedef enum logic [2:0] {
    TMRC_IDLE,
    TMRC_HDR,
    TMRC_BODY,
    TMRC_ISA,
    TMRC_EXC
  } tmrc_state_t;

endpackage

// ==== test/test_trace_reset_and_compression.sv ====
// Self-checking bench for the trace macrocell core.
// Assumes the sink model drives trace_ready; words are noted in order.
module test_trace_reset_and_compression;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk;
  logic                 resetn;
  logic                 por_n;
  logic                 core_reset;
  logic                 wp_ready;
  logic                 cfg_we;
  logic                 trace_valid;
  logic                 trace_ready;
  logic [31:0]          trace_data;
  tmrc_pkg::tmrc_wp_t   wp;
  tmrc_pkg::tmrc_ctrl_t cfg_wdata;
  tmrc_pkg::tmrc_ctrl_t cfg_rdata;
  logic [31:0]          exp_q[$];
  int                   fails;
  int                   n_compared;
  logic [3:0]           isa_x;

  tmrc_core tmrc_core_inst (.ref_clk(ref_clk), .resetn(resetn),
    .por_n(por_n), .core_reset(core_reset), .wp(wp), .wp_ready(wp_ready),
    .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .trace_valid(trace_valid), .trace_data(trace_data),
    .trace_ready(trace_ready));
  tmrc_sink_model tmrc_sink_model_inst (.ref_clk(ref_clk),
    .resetn(resetn), .trace_ready(trace_ready));

  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cfg_write(input logic [3:0] v);
    @(posedge ref_clk);
    cfg_we    <= 1'h1;
    cfg_wdata <= v;
    @(posedge ref_clk);
    cfg_we    <= 1'h0;
  endtask

  // Holds the waypoint until the edge that takes it
  task automatic send_wp(input logic d, p, b, input logic [31:0] a);
    @(posedge ref_clk);
    wp <= {1'h1, d, p, isa_x, b, a};
    for (int i = 0; i <= 300; i++) begin
      @(negedge ref_clk);
      if (wp_ready === 1'h1) break;
      if (i == 300) begin
        fails++;
        stop_test();
      end
    end
    @(posedge ref_clk);
    wp.valid <= 1'h0;
  endtask

  // Full address then three atoms; a bytecode step adds nothing
  task automatic run_block();
    exp_q.push_back(32'hb4d6f801);
    exp_q.push_back(32'h84808412);
    send_wp(1'h0, 1'h1, 1'h0, 32'h12345678);
    send_wp(1'h1, 1'h1, 1'h0, 32'h0);
    send_wp(1'h1, 1'h1, 1'h1, 32'h0);
    send_wp(1'h1, 1'h0, 1'h0, 32'h0);
    send_wp(1'h1, 1'h1, 1'h0, 32'h0);
    for (int i = 0; i <= 1000; i++) begin
      @(negedge ref_clk);
      if (exp_q.size() == 0) break;
      if (i == 1000) begin
        fails++;
        stop_test();
      end
    end
  endtask

  task automatic do_reset(input logic use_por);
    @(posedge ref_clk);
    if (use_por) por_n <= 1'h0;
    else resetn <= 1'h0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'h1;
    por_n  <= 1'h1;
  endtask

  // ********
  // Clock, watcher and sequence
  // ********
  always #2 ref_clk = ~ref_clk;

  // Sampled mid-cycle so valid and ready are settled
  always @(negedge ref_clk) begin
    if (resetn && por_n && trace_valid === 1'h1 && trace_ready === 1'h1) begin
      if (exp_q.size() == 0) check(trace_data, 32'hdead0000);
      else check(trace_data, exp_q.pop_front());
    end
  end

  initial begin
    ref_clk    = 1'h0;
    resetn     = 1'h0;
    por_n      = 1'h1;
    core_reset = 1'h0;
    wp         = '0;
    isa_x      = 4'h0;
    cfg_we     = 1'h0;
    cfg_wdata  = '0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'h1;
    send_wp(1'h1, 1'h1, 1'h0, 32'h0);
    check({28'h0, cfg_rdata}, 32'hc);
    cfg_write(4'h1);
    @(negedge ref_clk);
    check({28'h0, cfg_rdata}, 32'h1);
    $display("reset values done");
    // Broadcast sends a direct branch as an address; an isa change
    // adds its own byte; a zero last address byte still goes out
    cfg_write(4'h3);
    exp_q.push_back(32'hb4d6f801);
    exp_q.push_back(32'h00010e12);
    isa_x = 4'hd;
    send_wp(1'h1, 1'h1, 1'h0, 32'h12345678);
    isa_x = 4'h0;
    send_wp(1'h1, 1'h1, 1'h0, 32'h12345600);
    cfg_write(4'h1);
    run_block();
    $display("broadcast and isa done");
    exp_q.push_back(32'h010e4201);
    send_wp(1'h0, 1'h1, 1'h0, 32'h12345642);
    @(posedge ref_clk);
    core_reset <= 1'h1;
    repeat (4) @(posedge ref_clk);
    core_reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    run_block();
    check({28'h0, cfg_rdata}, 32'h1);
    $display("processor reset done");
    // A partial word is dropped by a programming abort, resetn and por_n
    for (int k = 0; k < 3; k++) begin
      send_wp(1'h0, 1'h1, 1'h0, 32'h12345642);
      repeat (4) @(posedge ref_clk);
      if (k == 0) cfg_write(4'h5);
      else do_reset(k == 2);
      @(negedge ref_clk);
      check({31'h0, trace_valid}, 32'h0);
      if (k > 0) check({28'h0, cfg_rdata}, 32'hc);
      cfg_write(4'h1);
      run_block();
      $display("abort case %0d done", k);
    end
    stop_test();
  end
endmodule

// ==== test/tmrc_core_monitor.sv ====
// Port assertions for the trace macrocell core.
// Assumes binding onto tmrc_core; everything runs on ref_clk.
`include "tmrc_defs.svh"

module tmrc_core_monitor (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 por_n,
  input wire logic                 core_reset,
  input wire tmrc_pkg::tmrc_wp_t   wp,
  input wire logic                 wp_ready,
  input wire logic                 cfg_we,
  input wire tmrc_pkg::tmrc_ctrl_t cfg_wdata,
  input wire tmrc_pkg::tmrc_ctrl_t cfg_rdata,
  input wire logic                 trace_valid,
  input wire logic      [31:0]     trace_data,
  input wire logic                 trace_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Properties
  // ********
  // Either reset source silences every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !por_n);

  logic tracing;
  logic take;
  // Mirrors the taken condition so a dropped waypoint shows up
  assign tracing = cfg_rdata.tren && !cfg_rdata.prog && !cfg_rdata.pwrdn;
  assign take    = wp.valid && wp_ready && tracing && !wp.bytecode;

  stall_hold_a: assert property (
    trace_valid && !trace_ready |=> trace_valid && $stable(trace_data))
    else $error("trace word lost or changed while stalled");
  rst_val_a: assert property (
    $rose(resetn && por_n) |-> !trace_valid && cfg_rdata == {`TMRC_PWRDN_RST,
      `TMRC_PROG_RST, `TMRC_BCAST_RST, `TMRC_TREN_RST})
    else $error("control fields not at reset values");
  cfg_write_a: assert property (
    cfg_we |=> cfg_rdata == $past(cfg_wdata))
    else $error("control write not stored");
  cfg_keep_a: assert property (
    !cfg_we |=> $stable(cfg_rdata))
    else $error("control fields changed without a write");
  prog_quiet_a: assert property (
    cfg_we && cfg_wdata.prog |=> !trace_valid [*3])
    else $error("output after programming abort");
  prog_ready_a: assert property (
    cfg_we && cfg_wdata.prog |-> ##[1:2] wp_ready)
    else $error("sequence not aborted by programming write");
  wp_busy_a: assert property (
    take && !(cfg_we && cfg_wdata.prog) |=> !wp_ready)
    else $error("second waypoint accepted mid sequence");
  seq_end_a: assert property (
    take |-> ##[1:200] wp_ready)
    else $error("waypoint sequence never ends");
  wp_skip_a: assert property (
    wp.valid && wp_ready && (wp.bytecode || !tracing) |=> wp_ready)
    else $error("ignored waypoint started a sequence");

  cover property (trace_valid && !trace_ready);
  cover property ($rose(core_reset));
  cover property (wp.valid && wp.bytecode && wp_ready);
  cover property (wp.valid && wp.isa_chg && wp_ready);
endmodule

bind tmrc_core tmrc_core_monitor tmrc_core_monitor_inst (
  .ref_clk(ref_clk), .resetn(resetn), .por_n(por_n),
  .core_reset(core_reset), .wp(wp), .wp_ready(wp_ready),
  .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .trace_valid(trace_valid), .trace_data(trace_data),
  .trace_ready(trace_ready)
);

// ==== test/tmrc_sink_model.sv ====
// Trace capture sink model for the macrocell output.
// Assumes ref_clk and resetn of the bench; stalls are pseudo-random.
module tmrc_sink_model (
  input wire logic ref_clk,
  input wire logic resetn,
  output logic     trace_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lfsr_q;

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Random ready drops test holding; runs of stalls stay short
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_q      <= 32'h9d0993b9;
      trace_ready <= 1'h0;
    end else begin
      lfsr_q      <= lfsr_step(lfsr_q);
      trace_ready <= lfsr_q[0] | lfsr_q[3];
    end
  end
endmodule
